// >>> rtl/astas_pkg.sv
// shared constants and types for the serial transmit and status block
package astas_pkg;
	localparam logic [7:0]  OFS_STATUS = 8'h00;
	localparam logic [7:0]  OFS_DATA   = 8'h04;
	localparam logic [7:0]  OFS_CTRL1  = 8'h08;
	localparam logic [7:0]  OFS_CTRL2  = 8'h0c;
	localparam logic [7:0]  OFS_CPU    = 8'h10;
	localparam logic [7:0]  OFS_BAUD   = 8'h14;
	localparam int          C1_WORD9   = 0;
	localparam int          C1_NINTH   = 1;
	localparam int          C1_PIE     = 2;
	localparam int          C2_TE      = 0;
	localparam int          C2_SBK     = 1;
	localparam int          C2_TIE     = 2;
	localparam int          C2_TX_COMPLETE_IRQ_EN    = 3;
	localparam int          C2_RIE     = 4;
	localparam int          C2_IDLE_IRQ_EN    = 5;
	localparam int          CPU_MASK   = 0;
	localparam logic [7:0]  STATUS_RST = 8'hc0;
	localparam logic [7:0]  CTRL1_RST  = 8'h00;
	localparam logic [7:0]  CTRL2_RST  = 8'h00;
	localparam logic [7:0]  CPU_RST    = 8'h00;
	localparam logic [15:0] BAUD_RST   = 16'h00d8;
	localparam int          FRAME_W    = 11;
	localparam logic [3:0]  LEN_8      = 4'ha;
	localparam logic [3:0]  LEN_9      = 4'hb;
	localparam logic [3:0]  LEN_MARK   = 4'h1;

	typedef enum logic [2:0] {FR_NONE, FR_DATA, FR_IDLE, FR_BREAK, FR_MARK} astas_frame_e;

	typedef struct packed {
		logic tx_empty;
		logic tx_complete;
		logic rx_ready;
		logic idle_line;
		logic overrun;
		logic noise;
		logic framing;
		logic parity;
	} astas_status_s;

	typedef struct packed {
		logic       valid;
		logic [8:0] data;
		logic       noise;
		logic       framing;
		logic       parity;
	} astas_rx_evt_s;
endpackage : astas_pkg

// >>> rtl/astas_serial.sv
// serial transmitter with status flags and apb register access
//
// Notes on behaviour
// - word length eight or nine bits
// - ninth bit comes from control one
// - data leaves least significant bit first
// - enabling transmitter sends one idle frame
// - status read then data write clears tx flags
// - write while busy lands in buffer
// - write while idle starts at once
// - buffer move sets empty flag, may interrupt
// - no move while empty flag set
// - data frame end sets complete flag
// - idle or break never sets complete
// - break repeats, then one mark bit
// - enable toggle sends idle, drops buffer
// - status resets with two tx flags set
// - received word sets ready flag, interrupts
// - idle flag rearms only after ready
// - overrun keeps buffered word, sets flag
// - noise flag, no own interrupt
// - framing flag, no own interrupt
// - framing plus overrun: transfer, overrun only
// - parity flag interrupts when enabled
`timescale 1ns/1ps
module astas_serial
	import astas_pkg::*;
(
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [7:0]    paddr,
	input  wire logic [31:0]   pwdata,
	output logic      [31:0]   prdata,
	output logic               pready,
	output logic               pslverr,
	input  wire astas_rx_evt_s rx_evt,
	input  wire logic          rx_idle_detect,
	output logic               txd,
	output logic               tx_oe,
	output logic               irq
);
	logic [7:0]    ctrl1;
	logic [7:0]    ctrl2;
	logic [7:0]    cpu_reg;
	logic [15:0]   baud;
	logic [15:0]   baud_cnt;
	logic          armed;
	astas_status_s st;
	logic [8:0]    rx_buffer;
	logic          idle_rearm;
	logic [7:0]    tx_buffer;
	logic          buf_full;
	logic          busy;
	astas_frame_e  kind;
	logic [FRAME_W-1:0] shift;
	logic [3:0]    bits_left;
	logic          after_break;
	logic          idle_pend;

	logic          fire;
	logic          wr_data;
	logic          rd_data;
	logic          rd_status;
	logic          clr_tx;
	logic          clr_rx;
	logic          te_rise;
	logic          tick;
	logic          frame_end;
	logic          can_start;
	logic          direct;
	logic          load_buf;
	logic          load;
	astas_frame_e  sel;
	logic [FRAME_W-1:0] pattern;
	logic [3:0]    sel_len;
	logic [31:0]   rd_mux;
	logic          mapped;

	function automatic logic [FRAME_W-1:0] make_frame(input astas_frame_e k, input logic [7:0] d,
		input logic nine, input logic t8);
		case (k)
			FR_DATA:  make_frame = nine ? {1'b1, t8, d, 1'b0} : {2'b11, d, 1'b0};
			FR_BREAK: make_frame = '0;
			default:  make_frame = '1;
		endcase
	endfunction : make_frame

	always_comb
	begin
		fire = psel && penable && pready;
		wr_data = fire && pwrite && paddr == OFS_DATA;
		rd_data = fire && !pwrite && paddr == OFS_DATA;
		rd_status = fire && !pwrite && paddr == OFS_STATUS;
		clr_tx = wr_data && armed;
		clr_rx = rd_data && armed;
		te_rise = fire && pwrite && paddr == OFS_CTRL2 && pwdata[C2_TE] && !ctrl2[C2_TE];
	end

	always_comb
	begin
		mapped = 1'b1;
		rd_mux = '0;
		case (paddr)
			OFS_STATUS: rd_mux = {24'h000000, st};
			OFS_DATA:   rd_mux = {23'h000000, rx_buffer};
			OFS_CTRL1:  rd_mux = {24'h000000, ctrl1};
			OFS_CTRL2:  rd_mux = {24'h000000, ctrl2};
			OFS_CPU:    rd_mux = {24'h000000, cpu_reg};
			OFS_BAUD:   rd_mux = {16'h0000, baud};
			default:    mapped = 1'b0;
		endcase
	end

	// one wait state so read data comes from a flop
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			pready <= 1'b0;
			prdata <= '0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel && penable && !pready;
			if (psel && penable && !pready)
			begin
				prdata <= rd_mux;
				pslverr <= !mapped;
			end
		end

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			ctrl1 <= CTRL1_RST;
			ctrl2 <= CTRL2_RST;
			cpu_reg <= CPU_RST;
			baud <= BAUD_RST;
		end
		else if (fire && pwrite)
		begin
			case (paddr)
				OFS_CTRL1: ctrl1 <= pwdata[7:0];
				OFS_CTRL2: ctrl2 <= pwdata[7:0];
				OFS_CPU:   cpu_reg <= pwdata[7:0];
				OFS_BAUD:  baud <= pwdata[15:0];
				default:   ;
			endcase
		end

	// any access other than the data register keeps the arm
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			armed <= 1'b0;
		else if (rd_status)
			armed <= 1'b1;
		else if (rd_data || wr_data)
			armed <= 1'b0;

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			baud_cnt <= BAUD_RST;
		else if (load || !busy || baud_cnt == 16'h0000)
			baud_cnt <= baud;
		else
			baud_cnt <= baud_cnt - 16'h0001;

	always_comb
	begin
		tick = busy && baud_cnt == 16'h0000;
		frame_end = tick && bits_left == 4'h1;
		can_start = ctrl2[C2_TE] && (!busy || frame_end);
		sel = FR_NONE;
		load_buf = 1'b0;
		if (can_start)
		begin
			if (ctrl2[C2_SBK])
				sel = FR_BREAK;
			else if (after_break)
				sel = FR_MARK;
			else if (idle_pend)
				sel = FR_IDLE;
			else if (buf_full && !st.tx_empty)
			begin
				sel = FR_DATA;
				load_buf = 1'b1;
			end
		end
		direct = wr_data && ctrl2[C2_TE] && !busy && sel == FR_NONE && !buf_full;
		if (direct)
			sel = FR_DATA;
		load = sel != FR_NONE;
		pattern = make_frame(sel, direct ? pwdata[7:0] : tx_buffer, ctrl1[C1_WORD9],
			ctrl1[C1_NINTH]);
		sel_len = sel == FR_MARK ? LEN_MARK : (ctrl1[C1_WORD9] ? LEN_9 : LEN_8);
	end

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			busy <= 1'b0;
			kind <= FR_NONE;
			shift <= '1;
			bits_left <= 4'h0;
			txd <= 1'b1;
			after_break <= 1'b0;
		end
		else if (load)
		begin
			busy <= 1'b1;
			kind <= sel;
			shift <= pattern;
			bits_left <= sel_len;
			txd <= pattern[0];
			after_break <= sel == FR_BREAK;
		end
		else if (tick)
		begin
			if (frame_end)
			begin
				busy <= 1'b0;
				kind <= FR_NONE;
				txd <= 1'b1;
			end
			else
			begin
				shift <= shift >> 1;
				txd <= shift[1];
				bits_left <= bits_left - 4'h1;
			end
		end

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			tx_oe <= 1'b0;
		else
			tx_oe <= ctrl2[C2_TE];

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			idle_pend <= 1'b0;
		else if (te_rise)
			idle_pend <= 1'b1;
		else if (load && sel == FR_IDLE)
			idle_pend <= 1'b0;

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			buf_full <= 1'b0;
			tx_buffer <= 8'h00;
		end
		else if (te_rise)
			buf_full <= 1'b0;
		else
		begin
			if (load_buf)
				buf_full <= 1'b0;
			// a write in the moving cycle refills the buffer instead of being lost
			if (wr_data && !direct)
			begin
				buf_full <= 1'b1;
				tx_buffer <= pwdata[7:0];
			end
		end

	// one process owns the whole status word; hardware set wins over the software clear
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			st.tx_empty <= STATUS_RST[7];
			st.tx_complete <= STATUS_RST[6];
			st.rx_ready <= STATUS_RST[5];
			st.idle_line <= STATUS_RST[4];
			st.overrun <= STATUS_RST[3];
			st.noise <= STATUS_RST[2];
			st.framing <= STATUS_RST[1];
			st.parity <= STATUS_RST[0];
			rx_buffer <= 9'h000;
			idle_rearm <= 1'b1;
		end
		else
		begin
			if (clr_rx)
			begin
				st.rx_ready <= 1'b0;
				st.idle_line <= 1'b0;
				st.overrun <= 1'b0;
				st.noise <= 1'b0;
				st.framing <= 1'b0;
				st.parity <= 1'b0;
			end
			if (load_buf || direct)
				st.tx_empty <= 1'b1;
			else if (clr_tx)
				st.tx_empty <= 1'b0;
			if (frame_end && kind == FR_DATA)
				st.tx_complete <= 1'b1;
			else if (clr_tx)
				st.tx_complete <= 1'b0;
			if (rx_idle_detect && idle_rearm)
			begin
				st.idle_line <= 1'b1;
				idle_rearm <= 1'b0;
			end
			if (rx_evt.valid)
			begin
				if (st.rx_ready && !rx_evt.framing)
					st.overrun <= 1'b1;
				else
				begin
					rx_buffer <= rx_evt.data;
					st.rx_ready <= 1'b1;
					idle_rearm <= 1'b1;
					if (st.rx_ready)
						st.overrun <= 1'b1;
					else
					begin
						st.noise <= rx_evt.noise;
						st.framing <= rx_evt.framing;
						st.parity <= rx_evt.parity;
					end
				end
			end
		end

	// noise and framing share the ready interrupt, no term of their own
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= !cpu_reg[CPU_MASK] && ((st.tx_empty && ctrl2[C2_TIE])
				|| (st.tx_complete && ctrl2[C2_TX_COMPLETE_IRQ_EN])
				|| ((st.rx_ready || st.overrun) && ctrl2[C2_RIE])
				|| (st.idle_line && ctrl2[C2_IDLE_IRQ_EN])
				|| (st.parity && ctrl1[C1_PIE]));

	buf_move_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		load_buf |=> st.tx_empty && busy && kind == FR_DATA)
		else $error("buffer move did not set empty flag");

	buf_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		buf_full && st.tx_empty && !te_rise |=> buf_full)
		else $error("buffer moved while empty flag set");

	direct_start_a: assert property (@(posedge pclk) disable iff (!presetn)
		direct |=> busy && st.tx_empty && !txd && !buf_full)
		else $error("direct write did not start frame");

	busy_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_data && busy && !frame_end |=> buf_full && tx_buffer == $past(pwdata[7:0]))
		else $error("write while busy not buffered");

	clear_seq_a: assert property (@(posedge pclk) disable iff (!presetn)
		clr_tx && !load_buf && !direct && !frame_end |=> !st.tx_empty && !st.tx_complete)
		else $error("clear sequence left tx flags set");

	tc_only_data_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(st.tx_complete) |-> $past(kind) == FR_DATA && $past(frame_end))
		else $error("complete flag set by non data frame");

	tc_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		frame_end && kind == FR_DATA |=> st.tx_complete ##1 st.tx_complete || $past(clr_tx))
		else $error("complete flag not set after data frame");

	break_repeat_a: assert property (@(posedge pclk) disable iff (!presetn)
		frame_end && ctrl2[C2_SBK] && ctrl2[C2_TE] |=> kind == FR_BREAK && !txd)
		else $error("break frame not repeated");

	te_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
		te_rise |=> idle_pend && !buf_full)
		else $error("enable toggle kept buffer or skipped idle");

	overrun_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
		rx_evt.valid && st.rx_ready && !rx_evt.framing |=> st.overrun && $stable(rx_buffer))
		else $error("overrun overwrote buffered word");

	overrun_frame_a: assert property (@(posedge pclk) disable iff (!presetn)
		rx_evt.valid && st.rx_ready && rx_evt.framing && !clr_rx
		|=> st.overrun && rx_buffer == $past(rx_evt.data) && st.framing == $past(st.framing))
		else $error("framing plus overrun handled wrong");

	idle_once_a: assert property (@(posedge pclk) disable iff (!presetn)
		!idle_rearm && !st.idle_line && !rx_evt.valid |=> !st.idle_line)
		else $error("idle flag set again without new word");
endmodule : astas_serial

// >>> verification/astas_remote.sv
// remote serial receiver that decodes the frames seen on the transmit line
`timescale 1ns/1ps
module astas_remote #(
	parameter int BIT = 4
) (
	input  wire logic       pclk,
	input  wire logic       txd,
	input  wire logic       nine,
	output logic      [8:0] word,
	output logic            stop_ok,
	output int              frames
);
	int i;
	logic [8:0] w;
	initial
	begin
		word = '0;
		stop_ok = 1'b0;
		frames = 0;
		forever
		begin
			// a run of break frames has no falling edge, so it counts once
			@(negedge txd);
			// sample mid bit so a one-cycle skew does no harm
			repeat (BIT + BIT / 2) @(posedge pclk);
			// built privately and shown whole, so it stands until the next frame ends
			w = '0;
			for (i = 0; i < (nine ? 9 : 8); i++)
			begin
				w[i] = txd;
				repeat (BIT) @(posedge pclk);
			end
			word = w;
			stop_ok = txd;
			frames++;
		end
	end
endmodule : astas_remote

// >>> verification/test_async_serial_tx_and_status.sv
// self-checking bench for the serial transmit and status block
`timescale 1ns/1ps
module test_async_serial_tx_and_status;
	import astas_pkg::*;
	localparam int BIT = 4;
	logic          pclk, presetn, psel, penable, pwrite, perr, nine;
	logic [7:0]    paddr;
	logic [31:0]   pwdata, prdata, q;
	logic          pready, pslverr, txd, tx_oe, irq, rx_idle_detect, stop_ok;
	astas_rx_evt_s rx_evt;
	logic [8:0]    word;
	int            frames, fail_count, total_checks, n0;

	astas_serial i_astas_serial (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_evt(rx_evt), .rx_idle_detect(rx_idle_detect), .txd(txd),
		.tx_oe(tx_oe), .irq(irq));
	astas_remote #(.BIT(BIT)) i_astas_remote (.pclk(pclk), .txd(txd), .nine(nine), .word(word),
		.stop_ok(stop_ok), .frames(frames));

	initial
	begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	task automatic conclude;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : conclude

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
			if (n > 20)
			begin
				fail_count++;
				conclude();
			end
		end while (pready !== 1'b1);
		q = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic st;
		apb(1'b0, OFS_STATUS, 32'h0);
	endtask : st

	// status access first, so the data write also clears the tx flags
	task automatic send(input logic [31:0] d);
		st();
		apb(1'b1, OFS_DATA, d);
	endtask : send

	task automatic wait_frames(input int target);
		int n;
		n = 0;
		while (frames < target)
		begin
			@(posedge pclk);
			n++;
			if (n > 2000)
			begin
				fail_count++;
				conclude();
			end
		end
		repeat (2 * BIT) @(posedge pclk);
	endtask : wait_frames

	task automatic rx(input logic [8:0] d, input logic [2:0] nfp);
		rx_evt <= '{1'b1, d, nfp[2], nfp[1], nfp[0]};
		@(posedge pclk);
		rx_evt <= '0;
		repeat (2) @(posedge pclk);
	endtask : rx

	task automatic idle_pulse;
		rx_idle_detect <= 1'b1;
		@(posedge pclk);
		rx_idle_detect <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask : idle_pulse

	task automatic t_reset;
		chk("txd idle", 32'(txd), 32'h1);
		st();
		chk("status reset", q, 32'hc0);
		apb(1'b1, OFS_STATUS, 32'h0);
		st();
		chk("status read only", q, 32'hc0);
		apb(1'b0, 8'h20, 32'h0);
		chk("unmapped err", 32'(perr), 32'h1);
		chk("unmapped data", q, 32'h0);
		apb(1'b1, OFS_BAUD, 32'(BIT - 1));
		apb(1'b1, OFS_CTRL2, 32'h1);
		repeat (12 * BIT) @(posedge pclk);
		chk("pin owned", 32'(tx_oe), 32'h1);
		chk("idle frame only", 32'(frames), 32'h0);
		st();
		chk("idle keeps flags", q, 32'hc0);
	endtask : t_reset

	task automatic t_tx;
		send(32'h3c);
		st();
		chk("empty at start", q, 32'h80);
		wait_frames(1);
		chk("word", 32'(word), 32'h03c);
		chk("stop", 32'(stop_ok), 32'h1);
		st();
		chk("complete", q, 32'hc0);
	endtask : t_tx

	task automatic t_pair;
		n0 = frames;
		send(32'h81);
		send(32'h7e);
		st();
		chk("buffer held", q, 32'h00);
		wait_frames(n0 + 1);
		chk("first word", 32'(word), 32'h081);
		st();
		chk("moved", q & 32'h80, 32'h80);
		wait_frames(n0 + 2);
		chk("second word", 32'(word), 32'h07e);
	endtask : t_pair

	task automatic t_nine;
		n0 = frames;
		apb(1'b1, OFS_CTRL1, 32'h3);
		nine = 1'b1;
		send(32'h55);
		wait_frames(n0 + 1);
		chk("nine bit word", 32'(word), 32'h155);
		apb(1'b1, OFS_CTRL1, 32'h0);
		nine = 1'b0;
	endtask : t_nine

	task automatic t_break;
		n0 = frames;
		apb(1'b1, OFS_CTRL2, 32'h3);
		wait_frames(n0 + 1);
		chk("break word", 32'(word), 32'h0);
		chk("break stop", 32'(stop_ok), 32'h0);
		repeat (12 * BIT) @(posedge pclk);
		chk("break repeats", 32'(txd), 32'h0);
		apb(1'b1, OFS_CTRL2, 32'h1);
		repeat (24 * BIT) @(posedge pclk);
		n0 = frames;
		send(32'ha6);
		wait_frames(n0 + 1);
		chk("after break", 32'(word), 32'h0a6);
	endtask : t_break

	task automatic t_toggle;
		n0 = frames;
		send(32'h12);
		send(32'h34);
		apb(1'b1, OFS_CTRL2, 32'h0);
		apb(1'b1, OFS_CTRL2, 32'h1);
		wait_frames(n0 + 1);
		chk("current word", 32'(word), 32'h012);
		repeat (30 * BIT) @(posedge pclk);
		chk("buffer dropped", 32'(frames - n0), 32'h1);
	endtask : t_toggle

	task automatic t_rx;
		apb(1'b1, OFS_CTRL1, 32'h4);
		rx(9'h0a5, 3'b100);
		apb(1'b0, OFS_DATA, 32'h0);
		chk("rx word", q, 32'h0a5);
		st();
		chk("unarmed keeps", q & 32'h3f, 32'h24);
		rx(9'h05a, 3'b000);
		st();
		chk("overrun", q & 32'h3f, 32'h2c);
		apb(1'b0, OFS_DATA, 32'h0);
		chk("kept word", q, 32'h0a5);
		st();
		chk("rx cleared", q & 32'h3f, 32'h00);
		rx(9'h066, 3'b000);
		rx(9'h099, 3'b010);
		st();
		chk("frame overrun", q & 32'h3f, 32'h28);
		apb(1'b0, OFS_DATA, 32'h0);
		chk("frame word", q, 32'h099);
		idle_pulse();
		st();
		chk("idle set", q & 32'h3f, 32'h10);
		apb(1'b0, OFS_DATA, 32'h0);
		idle_pulse();
		st();
		chk("idle not rearmed", q & 32'h3f, 32'h00);
		rx(9'h033, 3'b011);
		st();
		chk("parity", q & 32'h3f, 32'h23);
		repeat (2) @(posedge pclk);
		chk("parity irq", 32'(irq), 32'h1);
		apb(1'b1, OFS_CPU, 32'h1);
		repeat (2) @(posedge pclk);
		chk("masked irq", 32'(irq), 32'h0);
		apb(1'b1, OFS_CPU, 32'h0);
	endtask : t_rx

	task automatic t_irq;
		n0 = frames;
		apb(1'b1, OFS_CTRL1, 32'h0);
		apb(1'b1, OFS_CTRL2, 32'h09);
		repeat (2) @(posedge pclk);
		chk("complete irq", 32'(irq), 32'h1);
		apb(1'b1, OFS_CTRL2, 32'h11);
		repeat (2) @(posedge pclk);
		chk("ready irq", 32'(irq), 32'h1);
		apb(1'b1, OFS_CTRL2, 32'h05);
		repeat (2) @(posedge pclk);
		chk("empty irq quiet", 32'(irq), 32'h0);
		send(32'h5a);
		repeat (2) @(posedge pclk);
		chk("empty irq", 32'(irq), 32'h1);
		wait_frames(n0 + 1);
		chk("last word", 32'(word), 32'h05a);
	endtask : t_irq

	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		rx_evt = '0;
		rx_idle_detect = 1'b0;
		nine = 1'b0;
		fail_count = 0;
		total_checks = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_tx();
		t_pair();
		t_nine();
		t_break();
		t_toggle();
		t_rx();
		t_irq();
		conclude();
	end
endmodule : test_async_serial_tx_and_status
